/* File: dmct_timer.sv */
// dual mode compare timer: counters, compare, toggle outputs, registers
// assumes bus requests and pins synchronous to clk_in; irq controller outside
`timescale 1ns/1ns
module dmct_timer
    import dmct_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    // peripheral bus
    input  wire dmct_bus_s  bus_in,
    output logic [7:0]      rdata_out,
    // pins and loose control bits
    input  wire logic       event_input_in,
    input  wire logic       event_pin_function_in,
    input  wire logic       edge_polarity_in,
    input  wire logic       watch_tick_in,
    output logic            upper_toggle_out,
    output logic            lower_toggle_out,
    // interrupt requests
    input  wire logic       upper_irq_enable_in,
    input  wire logic       lower_irq_enable_in,
    input  wire logic       upper_irq_clear_in,
    input  wire logic       lower_irq_clear_in,
    output logic            upper_irq_request_out,
    output logic            lower_irq_request_out,
    output logic            upper_irq_out,
    output logic            lower_irq_out
);
    // ************************************************************
    // state
    // ************************************************************
    logic [7:0]          ctrl_ff;
    logic [7:0]          csr_ff;
    logic [7:0]          cstop_ff;
    logic [7:0]          ucnt_ff;
    logic [7:0]          lcnt_ff;
    logic [7:0]          ucmp_ff;
    logic [7:0]          lcmp_ff;
    logic [7:0]          temp_ff;
    logic [7:0]          armed_ff;
    logic [DMCT_PRE_W-1:0] pre_ff;
    logic [1:0]          wdiv_ff;
    logic                ev_prev_ff;
    logic                mh_prev_ff;
    logic                ml_prev_ff;
    logic                utog_ff;
    logic                ltog_ff;
    logic                ureq_ff;
    logic                lreq_ff;
    logic [7:0]          rdata_ff;

    // ************************************************************
    // decode
    // ************************************************************
    logic       mode8;
    logic       run;
    logic       wr_ctrl, wr_csr, wr_cntu, wr_cntl, wr_cmpu, wr_cmpl, wr_stop;
    logic       rd_csr, rd_cntu;
    logic       ev_level, ev_edge, tick32, tick16, tick4, tickw;
    logic       l_tick, u_tick;
    logic       eq16, equ, eql, m_h, m_l, mh_rise, ml_rise;
    logic       clr16, clru, clrl, ovf16, ovfu, lower_overflow_flag;
    logic       set_upper_overflow_flag, set_lower_overflow_flag;
    logic [7:0] nxt_csr;
    logic [7:0] flag_clr;

    assign mode8 = ctrl_ff[DMCT_MODE_BIT];
    assign run   = cstop_ff[DMCT_STOP_BIT];

    // write strobes per register; read strobes for status and upper count only
    always_comb begin
        wr_ctrl = 1'b0; wr_csr = 1'b0; wr_cntu = 1'b0; wr_cntl = 1'b0;
        wr_cmpu = 1'b0; wr_cmpl = 1'b0; wr_stop = 1'b0;
        if (bus_in.addr == DMCT_ADDR_CTRL) begin
            wr_ctrl = bus_in.wr;
        end else if (bus_in.addr == DMCT_ADDR_CSR) begin
            wr_csr = bus_in.wr;
        end else if (bus_in.addr == DMCT_ADDR_CNTU) begin
            wr_cntu = bus_in.wr;
        end else if (bus_in.addr == DMCT_ADDR_CNTL) begin
            wr_cntl = bus_in.wr;
        end else if (bus_in.addr == DMCT_ADDR_CMPU) begin
            wr_cmpu = bus_in.wr;
        end else if (bus_in.addr == DMCT_ADDR_CMPL) begin
            wr_cmpl = bus_in.wr;
        end else if (bus_in.addr == DMCT_ADDR_CSTOP) begin
            wr_stop = bus_in.wr;
        end
    end
    assign rd_csr  = bus_in.rd && (bus_in.addr == DMCT_ADDR_CSR);
    assign rd_cntu = bus_in.rd && (bus_in.addr == DMCT_ADDR_CNTU);

    // ************************************************************
    // clock sources
    // ************************************************************
    // pin reads high while not in event function, so enabling the
    // function while the pin is low gives a falling edge
    assign ev_level = event_input_in | ~event_pin_function_in;
    assign ev_edge  = edge_polarity_in ? (ev_level & ~ev_prev_ff)
                                       : (~ev_level & ev_prev_ff);
    assign tick32 = (pre_ff == DMCT_PRE_32);
    assign tick16 = (pre_ff[3:0] == DMCT_PRE_16);
    assign tick4  = (pre_ff[1:0] == DMCT_PRE_4);
    assign tickw  = watch_tick_in && (wdiv_ff == DMCT_PRE_4);

    // prescaler, watch divider and edge history
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pre_ff     <= '0;
            wdiv_ff    <= '0;
            ev_prev_ff <= 1'b1;
        end else begin
            ev_prev_ff <= ev_level;
            if (run) begin
                pre_ff <= pre_ff + 1'b1;
                if (watch_tick_in) begin
                    wdiv_ff <= wdiv_ff + 1'b1;
                end
            end
        end
    end

    // lower source: events or internal clocks, 011 counts nothing
    always_comb begin
        case (ctrl_ff[DMCT_CKSL_LSB +: 3])
            DMCT_SEL_EV0, DMCT_SEL_EV1, DMCT_SEL_EV2: l_tick = ev_edge;
            DMCT_SEL_DIV32: l_tick = tick32;
            DMCT_SEL_DIV16: l_tick = tick16;
            DMCT_SEL_DIV4:  l_tick = tick4;
            DMCT_SEL_WDIV4: l_tick = tickw;
            default:        l_tick = 1'b0;
        endcase
        l_tick = l_tick & run;
    end

    // upper source in byte mode; event pin never reaches it
    always_comb begin
        case (ctrl_ff[DMCT_CKSH_LSB +: 3])
            DMCT_SEL_DIV32: u_tick = tick32;
            DMCT_SEL_DIV16: u_tick = tick16;
            DMCT_SEL_DIV4:  u_tick = tick4;
            DMCT_SEL_WDIV4: u_tick = tickw;
            default:        u_tick = 1'b0;
        endcase
        u_tick = u_tick & run & mode8;
    end

    // ************************************************************
    // compare and overflow
    // ************************************************************
    assign eq16 = ({ucnt_ff, lcnt_ff} == {ucmp_ff, lcmp_ff});
    assign equ  = (ucnt_ff == ucmp_ff);
    assign eql  = (lcnt_ff == lcmp_ff);
    assign m_h  = mode8 ? equ : eq16;
    assign m_l  = mode8 & eql;
    // one toggle per match period, not per cycle of equality
    assign mh_rise = run & m_h & ~mh_prev_ff;
    assign ml_rise = run & m_l & ~ml_prev_ff;

    // clear happens on the count event after the match
    assign clr16 = eq16 & csr_ff[DMCT_UPPER_MATCH_CLEAR_EN_BIT];
    assign clru  = equ & csr_ff[DMCT_UPPER_MATCH_CLEAR_EN_BIT];
    assign clrl  = eql & csr_ff[DMCT_LOWER_MATCH_CLEAR_EN_BIT];
    assign ovf16 = ~mode8 & l_tick & ~clr16 & ({ucnt_ff, lcnt_ff} == 16'hffff);
    assign ovfu  = u_tick & ~clru & (ucnt_ff == DMCT_BYTE_MAX);
    assign lower_overflow_flag  = mode8 & l_tick & ~clrl & (lcnt_ff == DMCT_BYTE_MAX);
    assign set_upper_overflow_flag = ovf16 | ovfu;
    assign set_lower_overflow_flag = lower_overflow_flag;

    // match history for edge detection
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mh_prev_ff <= 1'b0;
            ml_prev_ff <= 1'b0;
        end else begin
            mh_prev_ff <= m_h;
            ml_prev_ff <= m_l;
        end
    end

    // ************************************************************
    // counters
    // ************************************************************
    // cpu writes override counting in the same cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ucnt_ff <= DMCT_RST_CNT;
            lcnt_ff <= DMCT_RST_CNT;
        end else if (!mode8) begin
            if (wr_cntl) begin
                {ucnt_ff, lcnt_ff} <= {temp_ff, bus_in.wdata};
            end else if (l_tick) begin
                if (clr16) begin
                    {ucnt_ff, lcnt_ff} <= 16'h0000;
                end else begin
                    {ucnt_ff, lcnt_ff} <= {ucnt_ff, lcnt_ff} + 16'h0001;
                end
            end
        end else begin
            if (wr_cntu) begin
                ucnt_ff <= bus_in.wdata;
            end else if (u_tick) begin
                ucnt_ff <= clru ? DMCT_RST_CNT : ucnt_ff + 8'h01;
            end
            if (wr_cntl) begin
                lcnt_ff <= bus_in.wdata;
            end else if (l_tick) begin
                lcnt_ff <= clrl ? DMCT_RST_CNT : lcnt_ff + 8'h01;
            end
        end
    end

    // compare registers; wide writes land as one 16-bit value
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ucmp_ff <= DMCT_RST_CMP;
            lcmp_ff <= DMCT_RST_CMP;
        end else if (!mode8) begin
            if (wr_cmpl) begin
                ucmp_ff <= temp_ff;
                lcmp_ff <= bus_in.wdata;
            end
        end else begin
            if (wr_cmpu) begin
                ucmp_ff <= bus_in.wdata;
            end
            if (wr_cmpl) begin
                lcmp_ff <= bus_in.wdata;
            end
        end
    end

    // byte latch: upper write parks data, upper count read parks lower
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            temp_ff <= 8'h00;
        end else if (!mode8) begin
            if (wr_cntu || wr_cmpu) begin
                temp_ff <= bus_in.wdata;
            end else if (rd_cntu) begin
                temp_ff <= lcnt_ff;
            end
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_ff  <= DMCT_RST_CTRL;
            cstop_ff <= DMCT_RST_CSTOP;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= bus_in.wdata;
            end
            if (wr_stop) begin
                cstop_ff <= bus_in.wdata;
            end
        end
    end

    // flags: cleared by a zero only after being read as one; set wins
    always_comb begin
        flag_clr = wr_csr ? (armed_ff & ~bus_in.wdata & DMCT_FLAG_MASK) : 8'h00;
        nxt_csr  = csr_ff & ~flag_clr;
        if (wr_csr) begin
            nxt_csr = (nxt_csr & DMCT_FLAG_MASK) | (bus_in.wdata & ~DMCT_FLAG_MASK);
        end
        nxt_csr[DMCT_UPPER_OVERFLOW_FLAG_BIT] = nxt_csr[DMCT_UPPER_OVERFLOW_FLAG_BIT] | set_upper_overflow_flag;
        nxt_csr[DMCT_UPPER_MATCH_FLAG_BIT] = nxt_csr[DMCT_UPPER_MATCH_FLAG_BIT] | mh_rise;
        nxt_csr[DMCT_LOWER_OVERFLOW_FLAG_BIT] = nxt_csr[DMCT_LOWER_OVERFLOW_FLAG_BIT] | set_lower_overflow_flag;
        nxt_csr[DMCT_LOWER_MATCH_FLAG_BIT] = nxt_csr[DMCT_LOWER_MATCH_FLAG_BIT] | ml_rise;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            csr_ff   <= DMCT_RST_CSR;
            armed_ff <= 8'h00;
        end else begin
            csr_ff <= nxt_csr;
            if (rd_csr) begin
                armed_ff <= csr_ff & DMCT_FLAG_MASK;
            end else begin
                armed_ff <= armed_ff & ~flag_clr;
            end
        end
    end

    // ************************************************************
    // toggle outputs and interrupt requests
    // ************************************************************
    // a level write takes effect at once and beats a same-cycle match
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            utog_ff <= 1'b0;
            ltog_ff <= 1'b0;
        end else if (wr_ctrl) begin
            utog_ff <= bus_in.wdata[DMCT_UPPER_OUTPUT_LEVEL_BIT];
            ltog_ff <= bus_in.wdata[DMCT_LOWER_OUTPUT_LEVEL_BIT];
        end else begin
            if (mh_rise) begin
                utog_ff <= ~utog_ff;
            end
            if (ml_rise) begin
                ltog_ff <= ~ltog_ff;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ureq_ff <= 1'b0;
            lreq_ff <= 1'b0;
        end else begin
            ureq_ff <= (ureq_ff & ~upper_irq_clear_in) | mh_rise
                       | (set_upper_overflow_flag & csr_ff[DMCT_UPPER_OVERFLOW_IRQ_EN_BIT]);
            lreq_ff <= (lreq_ff & ~lower_irq_clear_in) | ml_rise
                       | (set_lower_overflow_flag & csr_ff[DMCT_LOWER_OVERFLOW_IRQ_EN_BIT]);
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_ff <= 8'h00;
        end else if (bus_in.rd) begin
            if (bus_in.addr == DMCT_ADDR_CSR) begin
                rdata_ff <= csr_ff;
            end else if (bus_in.addr == DMCT_ADDR_CNTU) begin
                rdata_ff <= ucnt_ff;
            end else if (bus_in.addr == DMCT_ADDR_CNTL) begin
                rdata_ff <= mode8 ? lcnt_ff : temp_ff;
            end else if (bus_in.addr == DMCT_ADDR_CMPU) begin
                rdata_ff <= ucmp_ff;
            end else if (bus_in.addr == DMCT_ADDR_CMPL) begin
                rdata_ff <= lcmp_ff;
            end else if (bus_in.addr == DMCT_ADDR_CSTOP) begin
                rdata_ff <= cstop_ff;
            end else begin
                rdata_ff <= DMCT_READ_FILL; // control is write-only
            end
        end
    end

    assign rdata_out             = rdata_ff;
    assign upper_toggle_out      = utog_ff;
    assign lower_toggle_out      = ltog_ff;
    assign upper_irq_request_out = ureq_ff;
    assign lower_irq_request_out = lreq_ff;
    assign upper_irq_out         = ureq_ff & upper_irq_enable_in;
    assign lower_irq_out         = lreq_ff & lower_irq_enable_in;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence upper_byte_wr_s;
        wr_cntu && !mode8;
    endsequence
    sequence lower_byte_wr_s;
        wr_cntl && !mode8 && !wr_ctrl;
    endsequence

    wide_latch_a: assert property ((upper_byte_wr_s ##1 lower_byte_wr_s) |=>
        ucnt_ff == $past(bus_in.wdata, 2) && lcnt_ff == $past(bus_in.wdata))
        else $error("wide count write not taken as one value");
    reset_values_a: assert property ($fell(srst_in) |->
        ucnt_ff == DMCT_RST_CNT && lcnt_ff == DMCT_RST_CNT && ucmp_ff == DMCT_RST_CMP
        && lcmp_ff == DMCT_RST_CMP && ctrl_ff == DMCT_RST_CTRL) else $error("reset values wrong");
    wide_ovf_a: assert property (ovf16 && !wr_cntl |=> csr_ff[DMCT_UPPER_OVERFLOW_FLAG_BIT] &&
        ucnt_ff == 8'h00 && lcnt_ff == 8'h00)
        else $error("wide wrap did not set upper overflow");
    lower_ovf_a: assert property (lower_overflow_flag && csr_ff[DMCT_LOWER_OVERFLOW_IRQ_EN_BIT] |=>
        csr_ff[DMCT_LOWER_OVERFLOW_FLAG_BIT] && lreq_ff) else $error("lower wrap lost");
    match_clear_a: assert property (!mode8 && l_tick && clr16 && !wr_cntl
        && !wr_ctrl |=> {ucnt_ff, lcnt_ff} == 16'h0000)
        else $error("match clear did not reload zero");
    match_flag_a: assert property (mh_rise |=> csr_ff[DMCT_UPPER_MATCH_FLAG_BIT]
        && ureq_ff) else $error("upper match flag or request missing");
    toggle_match_a: assert property (ml_rise && !wr_ctrl |=>
        ltog_ff != $past(ltog_ff)) else $error("lower toggle did not invert");
    level_write_a: assert property (wr_ctrl |=>
        utog_ff == $past(bus_in.wdata[DMCT_UPPER_OUTPUT_LEVEL_BIT]))
        else $error("upper level write not applied");
    standby_hold_a: assert property (!run && !wr_cntu && !wr_cntl && !wr_stop
        |=> $stable(ucnt_ff) && $stable(lcnt_ff)) else $error("counter moved in standby");
    flag_guard_a: assert property (wr_csr && !armed_ff[DMCT_LOWER_MATCH_FLAG_BIT] &&
        csr_ff[DMCT_LOWER_MATCH_FLAG_BIT] |=> csr_ff[DMCT_LOWER_MATCH_FLAG_BIT])
        else $error("unread flag cleared");
endmodule

/* File: dmct_pkg.sv */
// constants, field layouts and bus carrier for the dual mode compare timer
// assumes one 20 MHz system clock and an 8-bit peripheral bus master
// Operation
// - two byte counters cascade into wide counter
// - reset clears both count bytes
// - upper select bit2 low: single wide counter
// - wide wrap sets upper overflow, optional request
// - wide match clears counter when enabled
// - upper select bit2 high: two byte counters
// - byte wrap sets its overflow, optional request
// - byte match clears own counter when enabled
// - reset sets both compare bytes to ones
// - wide match sets upper flag and request
// - byte match sets its flag and request
// - wide match inverts upper toggle output
// - byte match inverts its own toggle output
// - control bit 7 presets upper toggle level
// - control bit 3 presets lower toggle level
// - control register write-only, resets to zero
// - upper select encoding, watch clock div four
// - lower select encoding, event or internal clocks
// - event edge polarity selectable, lower counter only
// - pin function switch while low may count
// - wide writes and count reads pass through byte latch
// - flags cleared by zero write after read
// - module stop bit low holds timer still
package dmct_pkg;
    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [15:0] DMCT_ADDR_CTRL  = 16'hffb6;
    localparam logic [15:0] DMCT_ADDR_CSR   = 16'hffb7;
    localparam logic [15:0] DMCT_ADDR_CNTU  = 16'hffb8;
    localparam logic [15:0] DMCT_ADDR_CNTL  = 16'hffb9;
    localparam logic [15:0] DMCT_ADDR_CMPU  = 16'hffba;
    localparam logic [15:0] DMCT_ADDR_CMPL  = 16'hffbb;
    localparam logic [15:0] DMCT_ADDR_CSTOP = 16'hfffa;

    // ************************************************************
    // reset values and read fill
    // ************************************************************
    localparam logic [7:0] DMCT_RST_CTRL  = 8'h00;
    localparam logic [7:0] DMCT_RST_CSR   = 8'h00;
    localparam logic [7:0] DMCT_RST_CNT   = 8'h00;
    localparam logic [7:0] DMCT_RST_CMP   = 8'hff;
    localparam logic [7:0] DMCT_RST_CSTOP = 8'hff;
    localparam logic [7:0] DMCT_READ_FILL = 8'hff;
    localparam logic [7:0] DMCT_BYTE_MAX  = 8'hff;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int DMCT_UPPER_OUTPUT_LEVEL_BIT   = 7;
    localparam int DMCT_MODE_BIT   = 6;
    localparam int DMCT_CKSH_LSB   = 4;
    localparam int DMCT_LOWER_OUTPUT_LEVEL_BIT   = 3;
    localparam int DMCT_CKSL_LSB   = 0;
    localparam int DMCT_UPPER_OVERFLOW_FLAG_BIT   = 7;
    localparam int DMCT_UPPER_MATCH_FLAG_BIT   = 6;
    localparam int DMCT_UPPER_OVERFLOW_IRQ_EN_BIT  = 5;
    localparam int DMCT_UPPER_MATCH_CLEAR_EN_BIT  = 4;
    localparam int DMCT_LOWER_OVERFLOW_FLAG_BIT   = 3;
    localparam int DMCT_LOWER_MATCH_FLAG_BIT   = 2;
    localparam int DMCT_LOWER_OVERFLOW_IRQ_EN_BIT  = 1;
    localparam int DMCT_LOWER_MATCH_CLEAR_EN_BIT  = 0;
    localparam int DMCT_STOP_BIT   = 2;
    localparam logic [7:0] DMCT_FLAG_MASK = 8'hcc;

    // ************************************************************
    // clock select codes and prescaler
    // ************************************************************
    localparam logic [2:0] DMCT_SEL_EV0   = 3'h0;
    localparam logic [2:0] DMCT_SEL_EV1   = 3'h1;
    localparam logic [2:0] DMCT_SEL_EV2   = 3'h2;
    localparam logic [2:0] DMCT_SEL_DIV32 = 3'h4;
    localparam logic [2:0] DMCT_SEL_DIV16 = 3'h5;
    localparam logic [2:0] DMCT_SEL_DIV4  = 3'h6;
    localparam logic [2:0] DMCT_SEL_WDIV4 = 3'h7;
    localparam int         DMCT_PRE_W     = 5;
    localparam logic [4:0] DMCT_PRE_32    = 5'h1f;
    localparam logic [3:0] DMCT_PRE_16    = 4'hf;
    localparam logic [1:0] DMCT_PRE_4     = 2'h3;

    // ************************************************************
    // bus carrier
    // ************************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } dmct_bus_s;
endpackage

/* File: dmct_cpu_model.sv */
// cpu bus master model for the compare timer
// assumes the read answer stands from one cycle after the strobe
`timescale 1ns/1ns
module dmct_cpu_model
    import dmct_pkg::*;
(
    // clock
    input  wire logic       clk_in,
    // peripheral bus
    output dmct_bus_s       bus_out,
    input  wire logic [7:0] rdata_in
);
    logic [7:0] rd_val;
    event       rd_done;
    // idle bus at time zero
    initial bus_out = '0;
    // a write is held until the edge that takes it
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1 bus_out = '{a, d, 1'b1, 1'b0};
        @(posedge clk_in);
        #1 bus_out.wr = 1'b0;
        bus_out.wdata = ~d; // released data never repeats itself
    endtask
    // wide pair: upper then lower byte on consecutive edges, strobe held up
    task automatic wr2(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        #1 bus_out = '{a, d[15:8], 1'b1, 1'b0};
        @(posedge clk_in);
        #1 bus_out = '{a + 16'h0001, d[7:0], 1'b1, 1'b0};
        @(posedge clk_in);
        #1 bus_out.wr = 1'b0;
        bus_out.wdata = ~d[7:0];
    endtask
    // a read hands its byte on once the answer stands
    task automatic rd(input logic [15:0] a);
        @(posedge clk_in);
        #1 bus_out = '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_in);
        #1 bus_out.rd = 1'b0;
        rd_val = rdata_in;
        -> rd_done;
    endtask
endmodule

/* File: dual_mode_compare_timer_tb.sv */
// self-checking bench for the dual mode compare timer
// assumes dmct_cpu_model as bus master; pins move 1 or 2 ns after edges
`timescale 1ns/1ns
module dual_mode_compare_timer_tb;
    import dmct_pkg::*;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    dmct_bus_s   bus;
    logic [7:0]  rdata, exp_q[$];
    logic        ev = 1'b0, wtk = 1'b0, ien_l = 1'b0, clr = 1'b0;
    logic        pf = 1'b1, pol = 1'b1;
    logic        tog_u, tog_l, req_u, req_l, irq_u, irq_l;
    logic [15:0] rnd;
    int          err_total = 0, check_count = 0, cyc = 0;

    dmct_cpu_model cpu (.clk_in(clk_in), .bus_out(bus), .rdata_in(rdata));
    dmct_timer uut (
        .clk_in(clk_in), .srst_in(srst_in), .bus_in(bus), .rdata_out(rdata),
        .event_input_in(ev), .event_pin_function_in(pf), .edge_polarity_in(pol),
        .watch_tick_in(wtk), .upper_toggle_out(tog_u), .lower_toggle_out(tog_l),
        .upper_irq_enable_in(1'b1), .lower_irq_enable_in(ien_l),
        .upper_irq_clear_in(clr), .lower_irq_clear_in(clr),
        .upper_irq_request_out(req_u), .lower_irq_request_out(req_l),
        .upper_irq_out(irq_u), .lower_irq_out(irq_l));

    // ************************************************************
    // clock, watch tick and hang guard
    // ************************************************************
    always #25 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        #1 wtk = (cyc % 8 == 0);
        if (cyc == 3000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // second process: each read answer against the oldest note
    always @(cpu.rd_done) check("read", cpu.rd_val, exp_q.pop_front());
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        cpu.wr({8'hff, a}, d);
    endtask
    task automatic r(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cpu.rd({8'hff, a});
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h4c58));
        // kept inside 4000..7fff so it never meets compare ffff or 0010
        rnd = {2'b01, 14'($urandom())};
        repeat (8) @(posedge clk_in);
        #1 srst_in = 1'b0;
        // reset values; control is write-only, unmapped reads as fill
        r(8'hb6, DMCT_READ_FILL);
        r(8'hb7, 8'h00);
        r(8'hb8, 8'h00);
        r(8'hb9, 8'h00);
        r(8'hba, 8'hff);
        r(8'hbb, 8'hff);
        r(8'hfa, 8'hff);
        r(8'hbc, DMCT_READ_FILL);
        check("tog_u", {7'h0, tog_u}, 8'h00);
        check("tog_l", {7'h0, tog_l}, 8'h00);
        // random wide value through the latch; idle pin, nothing counts
        cpu.wr2(16'hffb8, rnd);
        r(8'hb8, rnd[15:8]);
        r(8'hb9, rnd[7:0]);
        // preset levels act at once after the write
        w(8'hb6, 8'h88);
        check("tog_u", {7'h0, tog_u}, 8'h01);
        check("tog_l", {7'h0, tog_l}, 8'h01);
        // wide wrap on one event edge, then flag clearing
        w(8'hba, 8'h00);
        w(8'hbb, 8'h10);
        w(8'hb8, 8'hff);
        w(8'hb9, 8'hff);
        w(8'hb7, 8'h20);
        #1 ev = 1'b1;
        repeat (4) @(posedge clk_in);
        r(8'hb7, 8'ha0);
        r(8'hb8, 8'h00);
        check("irq_u", {7'h0, irq_u}, 8'h01);
        w(8'hb7, 8'h20);
        r(8'hb7, 8'h20);
        w(8'hb7, 8'he0);
        r(8'hb7, 8'h20);
        clr = 1'b1;
        @(posedge clk_in);
        #1 clr = 1'b0;
        // wide match at 0010 with clear on /4: must toggle twice
        w(8'hb8, 8'h00);
        w(8'hb9, 8'h00);
        w(8'hb7, 8'h30);
        w(8'hb6, 8'h06);
        for (int i = 0; i < 200 && tog_u !== 1'b1; i++) @(posedge clk_in);
        #1 check("tog_u", {7'h0, tog_u}, 8'h01);
        for (int i = 0; i < 200 && tog_u !== 1'b0; i++) @(posedge clk_in);
        #1 check("tog_u", {7'h0, tog_u}, 8'h00);
        check("req_u", {7'h0, req_u}, 8'h01);
        w(8'hfa, 8'hfb);
        r(8'hb7, 8'h70);
        w(8'hb8, 8'h00);
        w(8'hb9, 8'h12);
        repeat (20) @(posedge clk_in);
        r(8'hb8, 8'h00);
        r(8'hb9, 8'h12);
        // byte mode: upper /4 clear at 03, lower /16 wraps then matches
        w(8'hb6, 8'h65);
        w(8'hb8, 8'hfe);
        w(8'hb9, 8'hfe);
        w(8'hba, 8'h03);
        w(8'hbb, 8'h02);
        w(8'hb7, 8'h12);
        clr = 1'b1;
        @(posedge clk_in);
        #1 clr = 1'b0;
        w(8'hfa, 8'hff);
        repeat (100) @(posedge clk_in);
        w(8'hfa, 8'hfb);
        w(8'hb7, 8'h12);
        r(8'hb7, 8'hde);
        check("tog_l", {7'h0, tog_l}, 8'h01);
        check("req_l", {7'h0, req_l}, 8'h01);
        check("irq_l", {7'h0, irq_l}, 8'h00);
        ien_l = 1'b1;
        #1 check("irq_l", {7'h0, irq_l}, 8'h01);
        // flags read as one are now armed and clear by a zero write
        w(8'hb7, 8'h12);
        r(8'hb7, 8'h12);
        // falling edges count; enabling the pin function while low counts too
        w(8'hb6, 8'h00);
        cpu.wr2(16'hffb8, 16'h0000);
        w(8'hfa, 8'hff);
        pol = 1'b0;
        ev = 1'b0;
        @(posedge clk_in);
        #1 pf = 1'b0;
        @(posedge clk_in);
        #1 pf = 1'b1;
        repeat (2) @(posedge clk_in);
        r(8'hb8, 8'h00);
        r(8'hb9, 8'h02);
        // slow sources: /32, then watch/4 after a match clear, reach 0004
        cpu.wr2(16'hffba, 16'h0004);
        w(8'hb6, 8'h04);
        for (int i = 0; i < 300 && tog_u !== 1'b1; i++) @(posedge clk_in);
        #1 check("tog_u", {7'h0, tog_u}, 8'h01);
        w(8'hb6, 8'h07);
        for (int i = 0; i < 300 && tog_u !== 1'b1; i++) @(posedge clk_in);
        #1 check("tog_u", {7'h0, tog_u}, 8'h01);
        give_verdict();
    end
endmodule
